// File: hdl/pcru_pkg.sv
// package: register map, field positions, reset values and timing for the clock/reset unit
package pcru_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_AUDIO0   = 12'h0B0;
  localparam logic [11:0] OFS_AUDIO1   = 12'h0B4;
  localparam logic [11:0] OFS_USBPHY   = 12'h0CC;
  localparam logic [11:0] OFS_DRAMCFG  = 12'h0F4;
  localparam logic [11:0] OFS_MPLLCFG  = 12'h0F8;
  localparam logic [11:0] OFS_FABRST   = 12'h0FC;
  localparam logic [11:0] OFS_DRAMGATE = 12'h100;
  localparam logic [11:0] OFS_BACKEND  = 12'h104;
  localparam logic [11:0] OFS_FRONTEND = 12'h10C;
  localparam logic [11:0] OFS_LCD0     = 12'h118;
  // ==========================================================
  // writable-bit masks (reserved bits read zero)
  localparam logic [31:0] MSK_AUDIO    = 32'h8003_0000;
  localparam logic [31:0] MSK_USBPHY   = 32'h0001_0F07;
  localparam logic [31:0] MSK_DRAMCFG  = 32'h8001_000F;
  localparam logic [31:0] MSK_MPLLCFG  = 32'h0001_107F;
  localparam logic [31:0] MSK_FABRST   = 32'h8000_0000;
  localparam logic [31:0] MSK_DRAMGATE = 32'h0501_0003;
  localparam logic [31:0] MSK_DISP     = 32'h8700_000F;
  localparam logic [31:0] MSK_LCD0     = 32'h8700_0000;
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  localparam logic [31:0] RST_DRAMCFG  = 32'h0000_0001;
  localparam logic [31:0] RST_MPLLCFG  = 32'h0000_0030;
  localparam logic [31:0] RST_FABRST   = 32'h8000_0000;
  // ==========================================================
  // field positions
  localparam int GATE_BIT    = 31;
  localparam int AUD_SRC_LO  = 16;
  localparam int OHCI_BIT    = 16;
  localparam int H12M_BIT    = 11;
  localparam int HSIC_BIT    = 10;
  localparam int PHY1_BIT    = 9;
  localparam int PHY0_BIT    = 8;
  localparam int HSIC_RST    = 2;
  localparam int PHY1_RST    = 1;
  localparam int PHY0_RST    = 0;
  localparam int DRAM_RST    = 31;
  localparam int APPLY_BIT   = 16;
  localparam int DIV_LO      = 0;
  localparam int CHOICE_BIT  = 16;
  localparam int MODE_BIT    = 12;
  localparam int PHASE_LO    = 4;
  localparam int STEP_LO     = 0;
  localparam int BE_PASS     = 26;
  localparam int FE_PASS     = 24;
  localparam int DRC_PASS    = 16;
  localparam int CSI_PASS    = 1;
  localparam int VE_PASS     = 0;
  localparam int DSRC_LO     = 24;
  // ==========================================================
  // slew step codes: highest defined code
  localparam logic [3:0] STEP_MAX = 4'h9;
  // display source codes
  localparam logic [2:0] DSRC_VIDEO  = 3'h0;
  localparam logic [2:0] DSRC_PERI2X = 3'h2;
  localparam logic [2:0] DSRC_GPU    = 3'h3;
  localparam logic [2:0] DSRC_DISP   = 3'h5;
  localparam logic [2:0] LSRC_V1X    = 3'h0;
  localparam logic [2:0] LSRC_V2X    = 3'h2;
  localparam logic [2:0] LSRC_DSI    = 3'h4;
  // ==========================================================
  // timing: memory clock update settles after this time
  localparam int CLK_MHZ        = 40;
  localparam int APPLY_TIME_NS  = 100;
  localparam int APPLY_CYC      = (APPLY_TIME_NS * CLK_MHZ + 999) / 1000;
  // apply sequencer states
  typedef enum logic [1:0] {
    PCRU_IDLE = 2'b00,
    PCRU_WAIT = 2'b01,
    PCRU_LOAD = 2'b10
  } pcru_apply_e;
endpackage

// File: hdl/pcru_top.sv
// peripheral clock and reset control unit: register file and clock control outputs
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - audio port registers gate their special clock at bit 31, one runs it
// - audio source bits 17:16 pick 8x, 8x/2, 8x/4 or 1x audio pll
// - usb phy register bit 16 gates ohci special clock
// - bit 11 gates 12m hsic clock, crystal reference halved
// - bit 10 gates hsic special clock from hsic pll
// - bit 9 gates usb phy1 clock, bit 8 usb phy0 clock
// - bits 2,1,0 active-low resets for hsic, phy1, phy0; reset zero
// - dram config bit 31 low holds dram controller reset
// - writing 1 to bit 16 applies config; hardware clears when valid
// - memory clock is pll divided by field 3:0 plus one, reset 1
// - memory pll choice bit 16 picks pll a or pll b
// - bit 12 puts memory pll b in continuous scaling mode
// - step field 3:0 sets slew rate; undefined codes mean slowest
// - bits 6:4 set pll b phase compensation, reset three
// - fabric reset bit 31 low holds domain, resets high
// - dram access pass bits 26,24,16,1,0 for five clients
// - backend/frontend gate at bit 31, divider field 3:0 plus one
// - backend/frontend source bits 26:24; reserved codes unused
// - lcd channel 0 gate bit 31, source bits 26:24
module pcru_top (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        clock_settled_in,
  output logic      [31:0] rdata_out,
  output logic      [1:0]  audio_gate_out,
  output logic      [3:0]  audio_src_out,
  output logic      [4:0]  usb_gate_out,
  output logic      [2:0]  usb_reset_n_out,
  output logic             dram_ctrl_reset_n_out,
  output logic      [3:0]  memory_clock_div_out,
  output logic             memory_pll_choice_out,
  output logic             memory_pll_b_scaling_mode_out,
  output logic      [3:0]  memory_pll_b_slew_step_out,
  output logic      [2:0]  memory_pll_b_phase_comp_out,
  output logic             memory_fabric_run_out,
  output logic      [4:0]  dram_pass_out,
  output logic      [1:0]  disp_gate_out,
  output logic      [5:0]  disp_src_out,
  output logic      [7:0]  disp_div_out,
  output logic             lcd0_gate_out,
  output logic      [2:0]  lcd0_src_out
);
  import pcru_pkg::*;

  // all checks below run on the one clock and pause in reset
  default clocking pcru_cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  // ==========================================================
  // register storage
  logic [31:0] audio0_ff, audio1_ff, usbphy_ff, dramcfg_ff, mpll_ff;
  logic [31:0] fabrst_ff, dgate_ff, backend_ff, frontend_ff, lcd0_ff;
  logic [31:0] nxt_audio0, nxt_audio1, nxt_usbphy, nxt_dramcfg, nxt_mpll;
  logic [31:0] nxt_fabrst, nxt_dgate, nxt_backend, nxt_frontend, nxt_lcd0;
  logic [31:0] nxt_rdata;
  logic        apply_done;

  // masked write of one register; reserved bits stay zero
  function automatic logic [31:0] wmask(input logic [31:0] cur, input logic [31:0] d,
                                        input logic [31:0] m, input logic hit);
    wmask = hit ? (d & m) : cur;
  endfunction

  // legal display source codes keep last good value otherwise
  function automatic logic disp_ok(input logic [2:0] s);
    disp_ok = (s == DSRC_VIDEO) || (s == DSRC_PERI2X) || (s == DSRC_GPU) || (s == DSRC_DISP);
  endfunction
  function automatic logic lcd_ok(input logic [2:0] s);
    lcd_ok = (s == LSRC_V1X) || (s == LSRC_V2X) || (s == LSRC_DSI);
  endfunction

  // register write and read decode
  always_comb begin
    nxt_audio0   = wmask(audio0_ff,   wdata_in, MSK_AUDIO,    wr_in && addr_in == OFS_AUDIO0);
    nxt_audio1   = wmask(audio1_ff,   wdata_in, MSK_AUDIO,    wr_in && addr_in == OFS_AUDIO1);
    nxt_usbphy   = wmask(usbphy_ff,   wdata_in, MSK_USBPHY,   wr_in && addr_in == OFS_USBPHY);
    nxt_mpll     = wmask(mpll_ff,     wdata_in, MSK_MPLLCFG,  wr_in && addr_in == OFS_MPLLCFG);
    nxt_fabrst   = wmask(fabrst_ff,   wdata_in, MSK_FABRST,   wr_in && addr_in == OFS_FABRST);
    nxt_dgate    = wmask(dgate_ff,    wdata_in, MSK_DRAMGATE, wr_in && addr_in == OFS_DRAMGATE);
    nxt_backend  = wmask(backend_ff,  wdata_in, MSK_DISP,     wr_in && addr_in == OFS_BACKEND);
    nxt_frontend = wmask(frontend_ff, wdata_in, MSK_DISP,     wr_in && addr_in == OFS_FRONTEND);
    nxt_lcd0     = wmask(lcd0_ff,     wdata_in, MSK_LCD0,     wr_in && addr_in == OFS_LCD0);
    nxt_dramcfg  = dramcfg_ff;
    if (wr_in && addr_in == OFS_DRAMCFG) begin
      // software may only set the apply bit; a 0 write leaves it pending
      nxt_dramcfg = (wdata_in & MSK_DRAMCFG) | (dramcfg_ff & (32'h1 << APPLY_BIT));
    end
    if (apply_done) begin
      nxt_dramcfg[APPLY_BIT] = 1'b0;
    end
    if (wr_in && addr_in == OFS_DRAMCFG && wdata_in[APPLY_BIT]) begin
      nxt_dramcfg[APPLY_BIT] = 1'b1; // new request wins over completion
    end
    nxt_rdata = RST_ZERO;
    if (rd_in) begin
      unique case (addr_in)
        OFS_AUDIO0:   nxt_rdata = audio0_ff;
        OFS_AUDIO1:   nxt_rdata = audio1_ff;
        OFS_USBPHY:   nxt_rdata = usbphy_ff;
        OFS_DRAMCFG:  nxt_rdata = dramcfg_ff;
        OFS_MPLLCFG:  nxt_rdata = mpll_ff;
        OFS_FABRST:   nxt_rdata = fabrst_ff;
        OFS_DRAMGATE: nxt_rdata = dgate_ff;
        OFS_BACKEND:  nxt_rdata = backend_ff;
        OFS_FRONTEND: nxt_rdata = frontend_ff;
        OFS_LCD0:     nxt_rdata = lcd0_ff;
        default:      nxt_rdata = RST_ZERO; // unmapped reads zero
      endcase
    end
  end

  // register update
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      audio0_ff   <= RST_ZERO;
      audio1_ff   <= RST_ZERO;
      usbphy_ff   <= RST_ZERO;
      dramcfg_ff  <= RST_DRAMCFG;
      mpll_ff     <= RST_MPLLCFG;
      fabrst_ff   <= RST_FABRST;
      dgate_ff    <= RST_ZERO;
      backend_ff  <= RST_ZERO;
      frontend_ff <= RST_ZERO;
      lcd0_ff     <= RST_ZERO;
    end else begin
      audio0_ff   <= nxt_audio0;
      audio1_ff   <= nxt_audio1;
      usbphy_ff   <= nxt_usbphy;
      dramcfg_ff  <= nxt_dramcfg;
      mpll_ff     <= nxt_mpll;
      fabrst_ff   <= nxt_fabrst;
      dgate_ff    <= nxt_dgate;
      backend_ff  <= nxt_backend;
      frontend_ff <= nxt_frontend;
      lcd0_ff     <= nxt_lcd0;
    end
  end

  // ==========================================================
  // memory clock apply sequencer
  pcru_apply_e state_ff, nxt_state;
  logic [7:0]  wait_ff, nxt_wait;
  logic [3:0]  mdiv_ff, nxt_mdiv;

  // waits for the clock to settle, then loads the divider
  always_comb begin
    nxt_state  = state_ff;
    nxt_wait   = wait_ff;
    nxt_mdiv   = mdiv_ff;
    apply_done = 1'b0;
    unique case (state_ff)
      PCRU_IDLE: begin
        if (dramcfg_ff[APPLY_BIT]) begin
          nxt_state = PCRU_WAIT;
          nxt_wait  = 8'(APPLY_CYC - 1);
        end
      end
      PCRU_WAIT: begin
        if (wait_ff != 8'h00) begin
          nxt_wait = wait_ff - 8'h01;
        end else if (clock_settled_in) begin
          nxt_state = PCRU_LOAD;
        end
      end
      PCRU_LOAD: begin
        nxt_mdiv   = dramcfg_ff[DIV_LO +: 4];
        apply_done = 1'b1;
        nxt_state  = PCRU_IDLE;
      end
      default: nxt_state = PCRU_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff <= PCRU_IDLE;
      wait_ff  <= 8'h00;
      mdiv_ff  <= RST_DRAMCFG[3:0];
    end else begin
      state_ff <= nxt_state;
      wait_ff  <= nxt_wait;
      mdiv_ff  <= nxt_mdiv;
    end
  end

  // ==========================================================
  // output stage: every output registered
  logic [2:0] be_src_ff, fe_src_ff, lcd_src_ff;
  logic [2:0] nxt_be_src, nxt_fe_src, nxt_lcd_src;
  logic [3:0] nxt_step;

  // reserved source codes keep the previous select, undefined steps fall to slowest
  always_comb begin
    nxt_be_src  = disp_ok(backend_ff[DSRC_LO +: 3])  ? backend_ff[DSRC_LO +: 3]  : be_src_ff;
    nxt_fe_src  = disp_ok(frontend_ff[DSRC_LO +: 3]) ? frontend_ff[DSRC_LO +: 3] : fe_src_ff;
    nxt_lcd_src = lcd_ok(lcd0_ff[DSRC_LO +: 3])      ? lcd0_ff[DSRC_LO +: 3]     : lcd_src_ff;
    nxt_step    = (mpll_ff[STEP_LO +: 4] > STEP_MAX) ? 4'h0 : mpll_ff[STEP_LO +: 4];
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      be_src_ff  <= 3'h0;
      fe_src_ff  <= 3'h0;
      lcd_src_ff <= 3'h0;
      rdata_out  <= RST_ZERO;
      audio_gate_out <= 2'h0;
      audio_src_out  <= 4'h0;
      usb_gate_out   <= 5'h00;
      usb_reset_n_out <= 3'h0;
      dram_ctrl_reset_n_out <= 1'b0;
      memory_clock_div_out  <= RST_DRAMCFG[3:0];
      memory_pll_choice_out <= 1'b0;
      memory_pll_b_scaling_mode_out <= 1'b0;
      memory_pll_b_slew_step_out    <= 4'h0;
      memory_pll_b_phase_comp_out   <= RST_MPLLCFG[6:4];
      memory_fabric_run_out <= 1'b1;
      dram_pass_out  <= 5'h00;
      disp_gate_out  <= 2'h0;
      disp_src_out   <= 6'h00;
      disp_div_out   <= 8'h00;
      lcd0_gate_out  <= 1'b0;
      lcd0_src_out   <= 3'h0;
    end else begin
      be_src_ff  <= nxt_be_src;
      fe_src_ff  <= nxt_fe_src;
      lcd_src_ff <= nxt_lcd_src;
      rdata_out  <= nxt_rdata; // read data in the cycle after the strobe only
      audio_gate_out <= {audio1_ff[GATE_BIT], audio0_ff[GATE_BIT]};
      audio_src_out  <= {audio1_ff[AUD_SRC_LO +: 2], audio0_ff[AUD_SRC_LO +: 2]};
      usb_gate_out   <= {usbphy_ff[OHCI_BIT], usbphy_ff[H12M_BIT], usbphy_ff[HSIC_BIT],
                         usbphy_ff[PHY1_BIT], usbphy_ff[PHY0_BIT]};
      usb_reset_n_out <= {usbphy_ff[HSIC_RST], usbphy_ff[PHY1_RST], usbphy_ff[PHY0_RST]};
      dram_ctrl_reset_n_out <= dramcfg_ff[DRAM_RST];
      memory_clock_div_out  <= mdiv_ff;
      memory_pll_choice_out <= mpll_ff[CHOICE_BIT];
      memory_pll_b_scaling_mode_out <= mpll_ff[MODE_BIT];
      memory_pll_b_slew_step_out    <= nxt_step;
      memory_pll_b_phase_comp_out   <= mpll_ff[PHASE_LO +: 3];
      memory_fabric_run_out <= fabrst_ff[GATE_BIT];
      dram_pass_out  <= {dgate_ff[BE_PASS], dgate_ff[FE_PASS], dgate_ff[DRC_PASS],
                         dgate_ff[CSI_PASS], dgate_ff[VE_PASS]};
      disp_gate_out  <= {frontend_ff[GATE_BIT], backend_ff[GATE_BIT]};
      disp_src_out   <= {fe_src_ff, be_src_ff};
      disp_div_out   <= {frontend_ff[DIV_LO +: 4], backend_ff[DIV_LO +: 4]};
      lcd0_gate_out  <= lcd0_ff[GATE_BIT];
      lcd0_src_out   <= lcd_src_ff;
    end
  end

  // ==========================================================
  // checks
  sequence s_apply_req;
    dramcfg_ff[APPLY_BIT] && state_ff == PCRU_IDLE;
  endsequence
  sequence s_apply_load;
    ##[1:300] state_ff == PCRU_LOAD;
  endsequence

  a_apply_reaches_load: assert property (@(posedge clock_in) disable iff (rst_in)
    s_apply_req ##0 clock_settled_in |-> s_apply_load)
    else $error("apply did not reach load");
  a_apply_clears: assert property (@(posedge clock_in) disable iff (rst_in)
    (state_ff == PCRU_LOAD && !(wr_in && addr_in == OFS_DRAMCFG && wdata_in[APPLY_BIT]))
    |=> !dramcfg_ff[APPLY_BIT])
    else $error("apply bit not cleared");
  a_div_loaded: assert property (@(posedge clock_in) disable iff (rst_in)
    state_ff == PCRU_LOAD |=> ##1 memory_clock_div_out == $past(dramcfg_ff[3:0], 2))
    else $error("divider not loaded");
  a_step_fallback: assert property (@(posedge clock_in) disable iff (rst_in)
    mpll_ff[3:0] > STEP_MAX |=> memory_pll_b_slew_step_out == 4'h0)
    else $error("undefined step not slowest");
  a_usb_reset_out: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_in && addr_in == OFS_USBPHY |=> ##1 usb_reset_n_out == $past(wdata_in[2:0], 2))
    else $error("usb reset output mismatch");
  a_read_reserved: assert property (@(posedge clock_in) disable iff (rst_in)
    rd_in && addr_in == OFS_USBPHY |=> (rdata_out & ~MSK_USBPHY) == 32'h0)
    else $error("reserved bits nonzero");
  a_disp_src_legal: assert property (@(posedge clock_in) disable iff (rst_in)
    disp_ok(disp_src_out[2:0]) && disp_ok(disp_src_out[5:3]))
    else $error("reserved display source driven");
  a_fabric_gate: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_in && addr_in == OFS_FABRST |=> ##1 memory_fabric_run_out == $past(wdata_in[31], 2))
    else $error("fabric reset output mismatch");
  // port zero gate follows its register
  a_audio_gate: assert property (
    wr_in && addr_in == OFS_AUDIO0 |=> ##1 audio_gate_out[0] == $past(wdata_in[31], 2))
    else $error("audio gate mismatch");
  // port one source select
  a_audio_src: assert property (
    wr_in && addr_in == OFS_AUDIO1 |=> ##1 audio_src_out[3:2] == $past(wdata_in[17:16], 2))
    else $error("audio source mismatch");
  // ohci special clock gate
  a_ohci_gate: assert property (
    wr_in && addr_in == OFS_USBPHY |=> ##1 usb_gate_out[4] == $past(wdata_in[16], 2))
    else $error("ohci gate mismatch");
  // 12m and hsic pll gates
  a_hsic_gates: assert property (
    wr_in && addr_in == OFS_USBPHY |=> ##1 usb_gate_out[3:2] == $past(wdata_in[11:10], 2))
    else $error("hsic gate mismatch");
  // both phy clock gates
  a_phy_gates: assert property (
    wr_in && addr_in == OFS_USBPHY |=> ##1 usb_gate_out[1:0] == $past(wdata_in[9:8], 2))
    else $error("phy gate mismatch");
  // dram controller reset level
  a_ctrl_reset: assert property (
    wr_in && addr_in == OFS_DRAMCFG |=> ##1 dram_ctrl_reset_n_out == $past(wdata_in[31], 2))
    else $error("dram controller reset mismatch");
  // memory pll choice
  a_pll_choice: assert property (
    wr_in && addr_in == OFS_MPLLCFG |=> ##1 memory_pll_choice_out == $past(wdata_in[16], 2))
    else $error("pll choice mismatch");
  // pll b scaling mode
  a_scaling_mode: assert property (
    wr_in && addr_in == OFS_MPLLCFG |=> ##1 memory_pll_b_scaling_mode_out == $past(wdata_in[12], 2))
    else $error("scaling mode mismatch");
  // pll b phase compensation
  a_phase_comp: assert property (
    wr_in && addr_in == OFS_MPLLCFG |=> ##1 memory_pll_b_phase_comp_out == $past(wdata_in[6:4], 2))
    else $error("phase compensation mismatch");
  // five dram access pass bits
  a_dram_pass: assert property (
    wr_in && addr_in == OFS_DRAMGATE |=> ##1 dram_pass_out ==
      $past({wdata_in[26], wdata_in[24], wdata_in[16], wdata_in[1:0]}, 2))
    else $error("dram pass mismatch");
  // backend divider field
  a_backend_div: assert property (
    wr_in && addr_in == OFS_BACKEND |=> ##1 disp_div_out[3:0] == $past(wdata_in[3:0], 2))
    else $error("backend divider mismatch");
  // lcd channel gate
  a_lcd_gate: assert property (
    wr_in && addr_in == OFS_LCD0 |=> ##1 lcd0_gate_out == $past(wdata_in[31], 2))
    else $error("lcd gate mismatch");
  // read data idles at zero
  a_rdata_idle: assert property (
    !rd_in |=> rdata_out == 32'h0)
    else $error("read data not idle");
  // divider moves only on a load
  a_div_stable: assert property (
    state_ff != PCRU_LOAD |=> $stable(mdiv_ff))
    else $error("divider moved without apply");
endmodule
`default_nettype wire

// File: sim/tb_pcru_top.sv
// self-checking testbench for the peripheral clock and reset unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_pcru_top;
  import pcru_pkg::*;
  // ==========================================================
  // register table: offsets, reset values, all-ones pattern less the apply bit and illegal source codes, and its readback
  localparam logic [11:0] OFS [10] = '{OFS_AUDIO0, OFS_AUDIO1, OFS_USBPHY, OFS_DRAMCFG,
    OFS_MPLLCFG, OFS_FABRST, OFS_DRAMGATE, OFS_BACKEND, OFS_FRONTEND, OFS_LCD0};
  localparam logic [31:0] RSTV [10] = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_DRAMCFG,
    RST_MPLLCFG, RST_FABRST, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
  localparam logic [31:0] ONES [10] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
    32'hFFFE_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFDFF_FFFF,
    32'hFDFF_FFFF, 32'hFCFF_FFFF};
  localparam logic [31:0] BACK [10] = '{MSK_AUDIO, MSK_AUDIO, MSK_USBPHY, 32'h8000_000F,
    MSK_MPLLCFG, MSK_FABRST, MSK_DRAMGATE, 32'h8500_000F, 32'h8500_000F, 32'h8400_0000};
  localparam int UB [5] = '{8, 9, 10, 11, 16};
  localparam int PB [5] = '{0, 1, 16, 24, 26};
  // ==========================================================
  // design signals
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [11:0] addr_in = 12'h000;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        clock_settled_in = 1'b0;
  logic [31:0] rdata_out;
  logic [1:0]  audio_gate_out, disp_gate_out;
  logic [3:0]  audio_src_out, memory_clock_div_out, memory_pll_b_slew_step_out;
  logic [4:0]  usb_gate_out, dram_pass_out;
  logic [2:0]  usb_reset_n_out, memory_pll_b_phase_comp_out, lcd0_src_out;
  logic        dram_ctrl_reset_n_out, memory_pll_choice_out, memory_pll_b_scaling_mode_out;
  logic        memory_fabric_run_out, lcd0_gate_out;
  logic [5:0]  disp_src_out;
  logic [7:0]  disp_div_out;
  logic [53:0] outs;
  int          failures = 0;
  int          n_compared = 0;
  // all control outputs in one word for whole-state comparisons
  assign outs = {audio_gate_out, audio_src_out, usb_gate_out, usb_reset_n_out,
    dram_ctrl_reset_n_out, memory_clock_div_out, memory_pll_choice_out,
    memory_pll_b_scaling_mode_out, memory_pll_b_slew_step_out, memory_pll_b_phase_comp_out,
    memory_fabric_run_out, dram_pass_out, disp_gate_out, disp_src_out, disp_div_out,
    lcd0_gate_out, lcd0_src_out};
  pcru_top pcru_top_inst (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .clock_settled_in(clock_settled_in),
    .rdata_out(rdata_out), .audio_gate_out(audio_gate_out), .audio_src_out(audio_src_out),
    .usb_gate_out(usb_gate_out), .usb_reset_n_out(usb_reset_n_out),
    .dram_ctrl_reset_n_out(dram_ctrl_reset_n_out),
    .memory_clock_div_out(memory_clock_div_out), .memory_pll_choice_out(memory_pll_choice_out),
    .memory_pll_b_scaling_mode_out(memory_pll_b_scaling_mode_out),
    .memory_pll_b_slew_step_out(memory_pll_b_slew_step_out),
    .memory_pll_b_phase_comp_out(memory_pll_b_phase_comp_out),
    .memory_fabric_run_out(memory_fabric_run_out), .dram_pass_out(dram_pass_out),
    .disp_gate_out(disp_gate_out), .disp_src_out(disp_src_out), .disp_div_out(disp_div_out),
    .lcd0_gate_out(lcd0_gate_out), .lcd0_src_out(lcd0_src_out));
  // 40 mhz clock
  always #12.5 clock_in = ~clock_in;
  // ==========================================================
  // bus tasks: one-cycle strobes, back to back allowed
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    wr_in <= 1'b1;
    rd_in <= 1'b0;
    addr_in <= a;
    wdata_in <= d;
  endtask
  // read data stands in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // release the strobes and let the outputs follow the last write
  task automatic settle;
    @(posedge clock_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic s_reset;
    logic [31:0] r;
    for (int i = 0; i < 10; i++) begin
      rd(OFS[i], r);
      `CHK(r, RSTV[i])
    end
    rd(12'h0B8, r);
    `CHK(r, 32'h0000_0000)
    `CHK(outs, {15'h0, 4'h1, 6'h0, 3'h3, 1'b1, 25'h0})
  endtask
  // back-to-back writes of all ones less the apply bit and illegal source codes, reserved bits and an unmapped write dropped
  task automatic s_fill;
    logic [31:0] r;
    for (int i = 0; i < 10; i++) wr(OFS[i], ONES[i]);
    wr(12'h0F0, 32'hFFFF_FFFF);
    settle;
    `CHK(outs, {15'h7FFF, 4'h1, 9'h187, 1'b1, 5'h1F, 2'h3, 6'h2D, 8'hFF, 1'b1, 3'h4})
    for (int i = 0; i < 10; i++) begin
      rd(OFS[i], r);
      `CHK(r, BACK[i])
    end
    rd(12'h0F0, r);
    `CHK(r, 32'h0000_0000)
    for (int i = 0; i < 10; i++) wr(OFS[i], 32'h0000_0000);
    settle;
    `CHK(outs, {15'h0, 4'h1, 35'h0})
  endtask
  // single bits land on the right outputs
  task automatic s_bits;
    for (int i = 0; i < 5; i++) begin
      wr(OFS_USBPHY, (32'h1 << UB[i]) | (i < 3 ? 32'h1 << i : 32'h0));
      wr(OFS_DRAMGATE, 32'h1 << PB[i]);
      wr(OFS_AUDIO0, 32'h8000_0000 | ((i % 4) << 16));
      wr(OFS_AUDIO1, (3 - (i % 4)) << 16);
      settle;
      `CHK(usb_gate_out, 5'h1 << i)
      `CHK(usb_reset_n_out, i < 3 ? 3'h1 << i : 3'h0)
      `CHK(dram_pass_out, 5'h1 << i)
      `CHK(audio_src_out, {2'(3 - (i % 4)), 2'(i % 4)})
      `CHK(audio_gate_out, 2'b01)
    end
  endtask
  // every slew code, mode and pll choice
  task automatic s_step;
    for (int c = 0; c < 16; c++) begin
      wr(OFS_MPLLCFG, 32'(c) | ((c % 2) << 16) | (((c / 2) % 2) << 12) | 32'h0000_0050);
      settle;
      `CHK(memory_pll_b_slew_step_out, c <= 9 ? 4'(c) : 4'h0)
      `CHK(memory_pll_choice_out, 1'(c % 2))
      `CHK(memory_pll_b_scaling_mode_out, 1'((c / 2) % 2))
      `CHK(memory_pll_b_phase_comp_out, 3'h5)
    end
  endtask
  // every source code; reserved codes keep the last legal select
  task automatic s_src;
    logic [2:0] eb;
    logic [2:0] el;
    eb = 3'h0;
    el = 3'h0;
    for (int c = 0; c < 8; c++) begin
      wr(OFS_BACKEND, 32'h8000_0000 | (c << 24) | c);
      wr(OFS_FRONTEND, (c << 24) | (15 - c));
      wr(OFS_LCD0, 32'h8000_0000 | (c << 24));
      settle;
      if (c == 0 || c == 2 || c == 3 || c == 5) eb = 3'(c);
      if (c == 0 || c == 2 || c == 4) el = 3'(c);
      `CHK(disp_src_out, {eb, eb})
      `CHK(lcd0_src_out, el)
      `CHK(disp_div_out, {4'(15 - c), 4'(c)})
      `CHK({disp_gate_out, lcd0_gate_out}, 3'b011)
    end
  endtask
  // wait for the apply bit to clear, then the divider follows
  task automatic poll_apply(input logic [3:0] d);
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h0001_0000;
    while (r[16] !== 1'b0 && n < 40) begin
      rd(OFS_DRAMCFG, r);
      n++;
    end
    if (r[16] !== 1'b0) begin
      failures++;
      tally_and_finish;
    end
    `CHK(r, 32'h8000_0000 | d)
    repeat (2) @(posedge clock_in);
    #1;
    `CHK(memory_clock_div_out, d)
  endtask
  task automatic s_apply;
    logic [31:0] r;
    wr(OFS_DRAMCFG, 32'h8001_000F);
    settle;
    repeat (8) @(posedge clock_in);
    rd(OFS_DRAMCFG, r);
    `CHK(r, 32'h8001_000F)
    `CHK(memory_clock_div_out, 4'h1)
    `CHK(dram_ctrl_reset_n_out, 1'b1)
    wr(OFS_DRAMCFG, 32'h8000_000F);
    settle;
    rd(OFS_DRAMCFG, r);
    `CHK(r[16], 1'b1)
    @(posedge clock_in);
    clock_settled_in <= 1'b1;
    poll_apply(4'hF);
    wr(OFS_DRAMCFG, 32'h8001_0001);
    poll_apply(4'h1);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    s_reset;
    s_fill;
    s_bits;
    s_step;
    s_src;
    s_apply;
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    s_reset;
    tally_and_finish;
  end
  initial begin
    #1500000;
    failures++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
